/* File: tmc_pkg.sv */
/*
 Constants shared by the trigger mode control block: register indices,
 trigger source codes, commands, reset values and control states.
 Assumes a 32-bit APB slave where a register's byte address is four times
 its index.
*/
`default_nettype none

package tmc_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 18;
    localparam logic [15:0] IDX_CMD  = 16'h0000;
    localparam logic [15:0] IDX_SRC  = 16'h9c40;
    localparam logic [15:0] IDX_DIR  = 16'h9ca4;
    localparam logic [15:0] IDX_TERM = 16'h9cae;

    // ------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------
    localparam logic [31:0] SRC_FREE_RUN = 32'h0000_0000;
    localparam logic [31:0] SRC_RISING   = 32'h0000_4e20;
    localparam logic [31:0] SRC_FALLING  = 32'h0000_4e2a;
    localparam logic [31:0] SRC_ANY      = 32'h0000_4e3e;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    localparam logic [31:0] CMD_START = 32'h0000_0004;
    localparam logic [31:0] CMD_FORCE = 32'h0000_0010;
    localparam logic [31:0] CMD_STOP  = 32'h0000_0040;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [31:0] SRC_RST  = 32'h0000_0000;
    localparam logic        DIR_RST  = 1'h0;
    localparam logic        TERM_RST = 1'h0;
    localparam int unsigned FLAG_BIT = 0;

    // ------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_ARMED  = 2'h1,
        ST_REPLAY = 2'h3
    } tmc_state_e;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = {idx, 2'h0};
    endfunction

    // External edge source codes
    function automatic logic is_ext(input logic [31:0] src);
        is_ext = (src == SRC_RISING) || (src == SRC_FALLING) ||
                 (src == SRC_ANY);
    endfunction

endpackage

`default_nettype wire

/* File: tmc_edge_if.sv */
/*
 Edge events of the external trigger line, passed from the input
 synchroniser to the trigger control.
 Assumes both ends run on the same sample clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface tmc_edge_if;
    logic rise;
    logic fall;

    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

`default_nettype wire

/* File: tmc_edge_det.sv */
/*
 Synchroniser and edge detector for the external trigger input.
 Assumes the input may be asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_edge_det (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Trigger line
    input  wire logic trig_in,
    // Edge events
    tmc_edge_if.src   ev
);

    logic sync_a;
    logic sync_b;
    logic hist;

    // ------------------------------------------------------------
    // Two-stage synchroniser and history
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            hist   <= 1'b0;
        end else begin
            sync_a <= trig_in;
            sync_b <= sync_a;
            hist   <= sync_b;
        end
    end

    assign ev.rise = sync_b & ~hist;
    assign ev.fall = ~sync_b & hist;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sync_rise: assert property (
        @(posedge pclk) disable iff (!presetn)
        ev.rise |-> $past(trig_in, 2) && !$past(trig_in, 3))
        else $error("rise not two stages after input");

endmodule

`default_nettype wire

/* File: tmc_trigger_ctrl.sv */
/*
 Trigger mode control: APB registers, trigger source selection,
 forced trigger, external edge triggering and the shared trigger pin.
 Assumes a replay engine that takes replay_start and reports
 replay_done, and an external pad that merges trig_out and trig_oe.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none


module tmc_trigger_ctrl (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Trigger pin
    input  wire logic                       trig_in,
    output logic                            trig_out,
    output logic                            trig_oe,
    output logic                            term_en,
    // Replay engine
    output logic                            replay_start,
    input  wire logic                       replay_done
);

    tmc_edge_if ev_if ();

    tmc_pkg::tmc_state_e state;
    tmc_pkg::tmc_state_e next_state;

    logic [31:0] src;
    logic        dir;
    logic        term;
    logic        ext_mode;
    logic        hit_cmd;
    logic        hit_src;
    logic        hit_dir;
    logic        hit_term;
    logic        hit_any;
    logic        wr_en;
    logic        cmd_wr;
    logic        start_cmd;
    logic        force_cmd;
    logic        stop_cmd;
    logic        edge_hit;
    logic        fire;
    logic [31:0] rd_val;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    tmc_edge_det u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .trig_in (trig_in),
        .ev      (ev_if.src)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign hit_cmd  = paddr == tmc_pkg::reg_addr(tmc_pkg::IDX_CMD);
    assign hit_src  = paddr == tmc_pkg::reg_addr(tmc_pkg::IDX_SRC);
    assign hit_dir  = paddr == tmc_pkg::reg_addr(tmc_pkg::IDX_DIR);
    assign hit_term = paddr == tmc_pkg::reg_addr(tmc_pkg::IDX_TERM);
    assign hit_any  = hit_cmd | hit_src | hit_dir | hit_term;

    assign wr_en  = psel & penable & pready & pwrite & ~pslverr;
    assign cmd_wr = wr_en & hit_cmd;

    assign start_cmd = cmd_wr & (pwdata == tmc_pkg::CMD_START);
    assign force_cmd = cmd_wr & (pwdata == tmc_pkg::CMD_FORCE);
    assign stop_cmd  = cmd_wr & (pwdata == tmc_pkg::CMD_STOP);

    assign ext_mode = tmc_pkg::is_ext(src);

    // ------------------------------------------------------------
    // Edge selection
    // ------------------------------------------------------------
    always_comb begin
        edge_hit = 1'b0;
        case (src)
            tmc_pkg::SRC_RISING: begin
                edge_hit = ev_if.rise;
            end
            tmc_pkg::SRC_FALLING: begin
                edge_hit = ev_if.fall;
            end
            tmc_pkg::SRC_ANY: begin
                edge_hit = ev_if.rise | ev_if.fall;
            end
            default: begin
                edge_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src <= tmc_pkg::SRC_RST;
        end else if (wr_en && hit_src) begin
            src <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir <= tmc_pkg::DIR_RST;
        end else if (wr_en && hit_dir) begin
            dir <= pwdata[tmc_pkg::FLAG_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term <= tmc_pkg::TERM_RST;
        end else if (wr_en && hit_term) begin
            term <= pwdata[tmc_pkg::FLAG_BIT];
        end
    end

    // ------------------------------------------------------------
    // Trigger state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        fire       = 1'b0;
        case (state)
            tmc_pkg::ST_IDLE: begin
                if (start_cmd) begin
                    if (src == tmc_pkg::SRC_FREE_RUN) begin
                        next_state = tmc_pkg::ST_REPLAY;
                        fire       = 1'b1;
                    end else begin
                        next_state = tmc_pkg::ST_ARMED;
                    end
                end
            end
            tmc_pkg::ST_ARMED: begin
                if (stop_cmd) begin
                    next_state = tmc_pkg::ST_IDLE;
                end else if (force_cmd || (ext_mode && edge_hit)) begin
                    next_state = tmc_pkg::ST_REPLAY;
                    fire       = 1'b1;
                end
            end
            tmc_pkg::ST_REPLAY: begin
                if (replay_done || stop_cmd) begin
                    next_state = tmc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = tmc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= tmc_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Replay start and trigger pin
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            replay_start <= 1'b0;
        end else begin
            replay_start <= fire;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_oe <= 1'b0;
        end else begin
            trig_oe <= ~ext_mode & dir;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_out <= 1'b0;
        end else begin
            trig_out <= fire & ~ext_mode & dir;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_en <= 1'b0;
        end else begin
            term_en <= term & ext_mode;
        end
    end

    // ------------------------------------------------------------
    // APB read and answer
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0;
        if (hit_cmd) begin
            rd_val = {30'h0, state};
        end else if (hit_src) begin
            rd_val = src;
        end else if (hit_dir) begin
            rd_val = {31'h0, dir};
        end else if (hit_term) begin
            rd_val = {31'h0, term};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_val;
        end else begin
            prdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_src_store: assert property (
        wr_en && hit_src |=> src == $past(pwdata))
        else $error("source register not updated");

    a_free_run: assert property (
        state == tmc_pkg::ST_IDLE && start_cmd &&
        src == tmc_pkg::SRC_FREE_RUN
        |=> state == tmc_pkg::ST_REPLAY && replay_start)
        else $error("free run did not start replay");

    a_force_gate: assert property (
        force_cmd |=> replay_start == $past(state == tmc_pkg::ST_ARMED))
        else $error("forced trigger outside armed state");

    a_drv_off: assert property (
        !ext_mode && !dir |=> !trig_oe && !trig_out)
        else $error("driver on with direction zero");

    a_drv_on: assert property (
        !ext_mode && dir && fire |=> trig_oe && trig_out)
        else $error("internal trigger not driven out");

    a_out_mark: assert property (
        trig_out |-> replay_start && trig_oe)
        else $error("trigger output not at replay start");

    a_ext_input: assert property (
        ext_mode |=> !trig_oe && !trig_out)
        else $error("pin driven in external mode");

    a_rise_trig: assert property (
        state == tmc_pkg::ST_ARMED && src == tmc_pkg::SRC_RISING &&
        ev_if.rise && !stop_cmd |=> replay_start)
        else $error("rising edge missed");

    a_fall_trig: assert property (
        state == tmc_pkg::ST_ARMED && src == tmc_pkg::SRC_FALLING &&
        ev_if.fall && !stop_cmd |=> replay_start)
        else $error("falling edge missed");

    a_any_edge: assert property (
        state == tmc_pkg::ST_ARMED && src == tmc_pkg::SRC_ANY &&
        (ev_if.rise || ev_if.fall) && !stop_cmd |=> replay_start)
        else $error("edge of either polarity missed");

    a_replay_hold: assert property (
        state == tmc_pkg::ST_REPLAY && !replay_done && !stop_cmd
        |=> state == tmc_pkg::ST_REPLAY && !replay_start)
        else $error("retrigger during replay");

    a_term_gate: assert property (
        term_en |-> $past(term) && $past(ext_mode))
        else $error("termination outside input mode");

    a_term_off: assert property (
        !ext_mode
        |=> !term_en)
        else $error("termination on in internal mode");

    a_force_idle: assert property (
        state == tmc_pkg::ST_IDLE && force_cmd
        |=> state == tmc_pkg::ST_IDLE && !replay_start)
        else $error("forced trigger acted while idle");

    a_edge_idle: assert property (
        state == tmc_pkg::ST_IDLE && edge_hit && !start_cmd
        |=> state == tmc_pkg::ST_IDLE && !replay_start)
        else $error("edge acted while not armed");

endmodule

`default_nettype wire

/* File: tmc_ext_equip.sv */
/*
 External equipment on the shared trigger line: drives a level when
 the device leaves the pin, and counts pulses the device drives out.
 Assumes the device output wins whenever its enable is high.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_ext_equip (
    // Clock
    input  wire logic pclk,
    // Device side of the pin
    input  wire logic dev_out,
    input  wire logic dev_oe,
    // Line and received pulses
    output logic      line,
    output int        n_seen
);
    logic lvl = 1'b0;

    initial n_seen = 0;

    // Wire level from both parties
    always_comb line = (dev_oe === 1'b1) ? dev_out : lvl;

    always @(posedge pclk) begin
        if (dev_oe === 1'b1 && dev_out === 1'b1) begin
            n_seen <= n_seen + 1;
        end
    end

    // New level, promptly or after a lag
    task automatic drive(input logic v, input int lag);
        repeat (lag) @(posedge pclk);
        lvl <= v;
    endtask
endmodule

`default_nettype wire

/* File: tmc_trigger_ctrl_tb.sv */
/*
 Self-checking bench for the trigger mode control block.
 Assumes the APB timing and register map of the trigger control.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_trigger_ctrl_tb;
    logic                       pclk, presetn, psel, penable, pwrite;
    logic [tmc_pkg::ADDR_W-1:0] paddr;
    logic [31:0]                pwdata, prdata, rdv;
    logic                       pready, pslverr, trig_in, trig_out;
    logic                       trig_oe, term_en, replay_start, replay_done, e;
    int                         n_mismatch, checks_done, n_start, n_seen;

    tmc_trigger_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
        .trig_out(trig_out), .trig_oe(trig_oe), .term_en(term_en),
        .replay_start(replay_start), .replay_done(replay_done));

    tmc_ext_equip ext_u (.pclk(pclk), .dev_out(trig_out), .dev_oe(trig_oe),
        .line(trig_in), .n_seen(n_seen));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) n_start <= 0;
        else if (replay_start === 1'b1) n_start <= n_start + 1;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {idx, 2'h0}; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdv = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            results;
        end
    endtask

    task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(nm, exp, rdv);
    endtask

    task automatic starts(input string nm, input int exp);
        repeat (8) @(posedge pclk);
        chk(nm, exp, n_start);
    endtask

    task automatic done_pulse;
        @(posedge pclk) replay_done <= 1'b1;
        @(posedge pclk) replay_done <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdchk("cmd", tmc_pkg::IDX_CMD, 32'h0);
        rdchk("src", tmc_pkg::IDX_SRC, 32'h0);
        rdchk("dir", tmc_pkg::IDX_DIR, 32'h0);
        rdchk("term", tmc_pkg::IDX_TERM, 32'h0);
        apb(1'b1, tmc_pkg::IDX_SRC, tmc_pkg::SRC_RISING);
        rdchk("src", tmc_pkg::IDX_SRC, tmc_pkg::SRC_RISING);
        rdchk("hole", 16'h0001, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        apb(1'b1, tmc_pkg::IDX_SRC, tmc_pkg::SRC_FREE_RUN);
    endtask

    task automatic t_free;
        apb(1'b1, tmc_pkg::IDX_TERM, 32'h1);
        apb(1'b1, tmc_pkg::IDX_DIR, 32'h1);
        repeat (2) @(posedge pclk);
        chk("term_en", 32'h0, {31'h0, term_en});
        chk("trig_oe", 32'h1, {31'h0, trig_oe});
        chk("trig_out", 32'h0, {31'h0, trig_out});
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_START);
        starts("starts", 1);
        chk("seen", 32'h1, n_seen);
        rdchk("state", tmc_pkg::IDX_CMD, 32'h3);
        done_pulse;
        rdchk("state", tmc_pkg::IDX_CMD, 32'h0);
    endtask

    task automatic t_dir0;
        apb(1'b1, tmc_pkg::IDX_DIR, 32'h0);
        repeat (2) @(posedge pclk);
        chk("trig_oe", 32'h0, {31'h0, trig_oe});
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_START);
        starts("starts", 2);
        chk("seen", 32'h1, n_seen);
        done_pulse;
    endtask

    task automatic t_force;
        apb(1'b1, tmc_pkg::IDX_SRC, 32'h0000_0007);
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_FORCE);
        starts("starts", 2);
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_START);
        rdchk("state", tmc_pkg::IDX_CMD, 32'h1);
        starts("starts", 2);
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_FORCE);
        starts("starts", 3);
        done_pulse;
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_START);
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_STOP);
        rdchk("stopped", tmc_pkg::IDX_CMD, 32'h0);
        apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_FORCE);
        starts("after stop", 3);
    endtask

    task automatic t_edges;
        logic [31:0] src [3];
        logic        init [3];
        int          base;
        src = '{tmc_pkg::SRC_RISING, tmc_pkg::SRC_FALLING, tmc_pkg::SRC_ANY};
        init = '{1'b1, 1'b0, 1'b0};
        apb(1'b1, tmc_pkg::IDX_DIR, 32'h1);
        apb(1'b1, tmc_pkg::IDX_TERM, 32'h1);
        for (int i = 0; i < 3; i++) begin
            base = n_start;
            ext_u.drive(init[i], 0);
            apb(1'b1, tmc_pkg::IDX_SRC, src[i]);
            repeat (2) @(posedge pclk);
            chk("trig_oe", 32'h0, {31'h0, trig_oe});
            chk("term_en", 32'h1, {31'h0, term_en});
            apb(1'b1, tmc_pkg::IDX_CMD, tmc_pkg::CMD_START);
            ext_u.drive(~init[i], i);
            starts("first edge", base + ((i == 2) ? 1 : 0));
            ext_u.drive(init[i], i);
            starts("second edge", base + 1);
            ext_u.drive(~init[i], 0);
            ext_u.drive(init[i], 4);
            starts("in replay", base + 1);
            done_pulse;
            ext_u.drive(~init[i], 0);
            ext_u.drive(init[i], 4);
            starts("not armed", base + 1);
            chk("seen", 32'h1, n_seen);
        end
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = 32'h0; replay_done = 1'b0;
        n_mismatch = 0; checks_done = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_free;
        t_dir0;
        t_force;
        t_edges;
        results;
    end
endmodule

`default_nettype wire
